/* src/mid_alu.sv */
// combinational arithmetic and logic unit of the decoder core
`timescale 1ns/100ps
`default_nettype none

module mid_alu (
  input wire mid_pkg::mid_alu_op_t op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] x_in,
  input wire logic c_in,
  input wire logic dc_in,
  input wire logic [2:0] bit_in,
  output var mid_pkg::mid_alu_res_t res_out
);
  import mid_pkg::*;

  logic [8:0] sum;
  logic [4:0] hsum;
  logic [8:0] dif;
  logic [4:0] hdif;
  logic daa_lo;
  logic daa_hi;
  logic [8:0] daa_t;
  logic [8:0] daa_r;
  logic [7:0] bmask;

  // ----------------------------------------
  // adders
  // ----------------------------------------
  assign sum = {1'b0, x_in} + {1'b0, a_in};
  assign hsum = {1'b0, x_in[3:0]} + {1'b0, a_in[3:0]};
  assign dif = {1'b0, x_in} - {1'b0, a_in};
  assign hdif = {1'b0, x_in[3:0]} - {1'b0, a_in[3:0]};
  assign daa_lo = dc_in || (a_in[3:0] > 4'h9);
  assign daa_t = {1'b0, a_in} + (daa_lo ? 9'h006 : 9'h000);
  assign daa_hi = c_in || daa_t[8] || (daa_t[7:4] > 4'h9);
  assign daa_r = daa_t + (daa_hi ? 9'h060 : 9'h000);
  assign bmask = 8'h01 << bit_in;

  // ----------------------------------------
  // result select
  // ----------------------------------------
  always_comb begin
    res_out = '0;
    res_out.c = c_in;
    res_out.dc = dc_in;
    unique case (op_in)
      ALU_PASS: res_out.res = x_in;
      ALU_PASSA: res_out.res = a_in;
      ALU_ADD: begin
        res_out.res = sum[7:0];
        res_out.c = sum[8];
        res_out.dc = hsum[4];
      end
      ALU_SUB: begin
        res_out.res = dif[7:0];
        res_out.c = ~dif[8];
        res_out.dc = ~hdif[4];
      end
      ALU_OR: res_out.res = a_in | x_in;
      ALU_AND: res_out.res = a_in & x_in;
      ALU_XOR: res_out.res = a_in ^ x_in;
      ALU_COM: res_out.res = ~x_in;
      ALU_INC: res_out.res = x_in + 8'h01;
      ALU_DEC: res_out.res = x_in - 8'h01;
      ALU_RRC: begin
        res_out.res = {c_in, x_in[7:1]};
        res_out.c = x_in[0];
      end
      ALU_RLC: begin
        res_out.res = {x_in[6:0], c_in};
        res_out.c = x_in[7];
      end
      ALU_SWAP: res_out.res = {x_in[3:0], x_in[7:4]};
      ALU_ZERO: res_out.res = 8'h00;
      ALU_DAA: begin
        res_out.res = daa_r[7:0];
        res_out.c = daa_hi;
      end
      ALU_BCLR: res_out.res = x_in & ~bmask;
      ALU_BSET: res_out.res = x_in | bmask;
    endcase
    res_out.z = res_out.res == 8'h00;
    res_out.upd_z = op_in inside {ALU_PASS, ALU_ADD, ALU_SUB, ALU_OR, ALU_AND,
                                  ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_ZERO};
    res_out.upd_c = op_in inside {ALU_ADD, ALU_SUB, ALU_RRC, ALU_RLC, ALU_DAA};
    res_out.upd_dc = op_in inside {ALU_ADD, ALU_SUB};
  end

endmodule : mid_alu
`default_nettype wire

/* src/mid_core.sv */
// decode and execute core of the 8-bit controller
`timescale 1ns/100ps
`default_nettype none

module mid_core #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [mid_pkg::INSTR_W-1:0] instr_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic [7:0] ctrl_rdata_in,
  input wire logic wake_in,
  output logic [mid_pkg::PC_W-1:0] pc_out,
  output var mid_pkg::mid_bus_t bus_out,
  output logic [7:0] acc_out,
  output logic [7:0] status_out,
  output logic [7:0] bank_out,
  output logic [7:0] option_out,
  output logic int_en_out,
  output logic sleep_out,
  output logic wdt_clear_out,
  output logic exec_out
);
  import mid_pkg::*;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("stack depth must be a power of two and at least 2");
  end

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic ctrl_wr_op(input logic [INSTR_W-1:0] w);
    return (w[12:4] == 9'h000) && (w[3:0] >= CTRL_FIRST);
  endfunction : ctrl_wr_op

  function automatic logic ctrl_rd_op(input logic [INSTR_W-1:0] w);
    return (w[12:4] == 9'h001) && (w[3:0] >= CTRL_FIRST);
  endfunction : ctrl_rd_op

  function automatic mid_alu_op_t reg_alu_op(input logic [2:0] g, input logic hi);
    mid_alu_op_t op;
    op = ALU_PASS;
    unique case (g)
      3'h0: op = hi ? ALU_ZERO : ALU_PASSA;
      3'h1: op = hi ? ALU_DEC : ALU_SUB;
      3'h2: op = hi ? ALU_AND : ALU_OR;
      3'h3: op = hi ? ALU_ADD : ALU_XOR;
      3'h4: op = hi ? ALU_COM : ALU_PASS;
      3'h5: op = hi ? ALU_DEC : ALU_INC;
      3'h6: op = hi ? ALU_RLC : ALU_RRC;
      3'h7: op = hi ? ALU_INC : ALU_SWAP;
    endcase
    return op;
  endfunction : reg_alu_op

  function automatic mid_alu_op_t imm_alu_op(input logic [2:0] k);
    mid_alu_op_t op;
    op = ALU_PASS;
    unique case (k)
      3'h1: op = ALU_OR;
      3'h2: op = ALU_AND;
      3'h3: op = ALU_XOR;
      3'h5: op = ALU_SUB;
      3'h7: op = ALU_ADD;
      3'h0, 3'h4, 3'h6: op = ALU_PASS;
    endcase
    return op;
  endfunction : imm_alu_op

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic phase_reg;
  logic [INSTR_W-1:0] ir_reg;
  logic ir_ok_reg;
  logic skip_reg;
  logic stall_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [7:0] acc_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] bank_reg;
  logic [7:0] option_reg;
  logic int_en_reg;
  logic sleep_reg;
  logic wdt_clr_reg;
  logic exec_reg;
  logic [PC_W-1:0] stack_reg [STACK_DEPTH];
  logic [SP_W-1:0] sp_reg;
  mid_bus_t bus_reg;
  mid_alu_res_t alu;

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  logic phase_last;
  logic run;
  logic fetch;
  logic exe;

  assign phase_last = phase_reg == 1'(PHASES_PER_CYCLE - 1);
  assign run = ~sleep_reg;
  assign fetch = run & ~phase_last;
  assign exe = run & phase_last & ir_ok_reg;

  // ----------------------------------------
  // fetch-side address
  // ----------------------------------------
  logic [5:0] f_raddr;
  logic [5:0] f_eff;
  logic f_ctrl;
  logic [7:0] f_addr;

  assign f_raddr = instr_in[5:0];
  assign f_eff = (f_raddr == ADDR_IND) ? bank_reg[5:0] : f_raddr;
  assign f_ctrl = ctrl_wr_op(instr_in) || ctrl_rd_op(instr_in);
  assign f_addr = f_ctrl ? {4'h0, instr_in[3:0]}
                         : {bank_reg[BANK_LSB+:2], f_eff};

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  logic is_misc;
  logic is_reg;
  logic is_bit;
  logic is_br;
  logic is_imm;
  logic [2:0] grp;
  logic hi;
  logic dst_r;
  logic [1:0] bkind;
  logic [2:0] bitn;
  logic [2:0] ik;
  logic [7:0] kval;
  logic op_daa;
  logic op_acc_to_option_reg;
  logic op_sleep_op;
  logic op_watchdog_clear_op;
  logic op_eni;
  logic op_interrupt_disable_op;
  logic op_ret;
  logic op_interrupt_exit_pop;
  logic op_option_reg_to_acc;
  logic op_tbl;
  logic op_cwr;
  logic op_crd;
  logic op_pop_with_literal;

  assign is_misc = ir_reg[12:6] == 7'h00;
  assign is_reg = (ir_reg[12:11] == 2'b00) && !is_misc;
  assign is_bit = ir_reg[12:11] == 2'b01;
  assign is_br = ir_reg[12:11] == 2'b10;
  assign is_imm = ir_reg[12:11] == 2'b11;
  assign grp = ir_reg[10:8];
  assign hi = ir_reg[7];
  assign dst_r = ir_reg[6];
  assign bkind = ir_reg[10:9];
  assign bitn = ir_reg[8:6];
  assign ik = ir_reg[10:8];
  assign kval = ir_reg[7:0];
  assign op_daa = ir_reg == OP_DAA;
  assign op_acc_to_option_reg = ir_reg == OP_ACC_TO_OPTION_REG;
  assign op_sleep_op = ir_reg == OP_SLEEP_OP;
  assign op_watchdog_clear_op = ir_reg == OP_WATCHDOG_CLEAR_OP;
  assign op_eni = ir_reg == OP_ENI;
  assign op_interrupt_disable_op = ir_reg == OP_INTERRUPT_DISABLE_OP;
  assign op_ret = ir_reg == OP_RET;
  assign op_interrupt_exit_pop = ir_reg == OP_INTERRUPT_EXIT_POP;
  assign op_option_reg_to_acc = ir_reg == OP_OPTION_REG_TO_ACC;
  assign op_tbl = ir_reg == OP_TBL;
  assign op_cwr = ctrl_wr_op(ir_reg);
  assign op_crd = ctrl_rd_op(ir_reg);
  assign op_pop_with_literal = is_imm && (ik == 3'h4);

  // ----------------------------------------
  // operand and alu
  // ----------------------------------------
  logic [5:0] d_eff;
  logic [7:0] rval;
  logic [7:0] alu_x;
  mid_alu_op_t alu_op;
  logic alu_en;
  logic no_flags;

  assign d_eff = bus_reg.addr[5:0];
  assign rval = (d_eff == ADDR_PCL) ? pc_reg[7:0] :
                (d_eff == ADDR_STAT) ? status_reg :
                (d_eff == ADDR_BANK) ? bank_reg : reg_rdata_in;
  assign alu_x = is_imm ? kval : (op_tbl ? pc_reg[7:0] : rval);
  assign alu_op = is_reg ? reg_alu_op(grp, hi) :
                  is_imm ? imm_alu_op(ik) :
                  (is_bit && bkind == 2'b00) ? ALU_BCLR :
                  (is_bit && bkind == 2'b01) ? ALU_BSET :
                  op_daa ? ALU_DAA :
                  op_tbl ? ALU_ADD : ALU_PASS;
  assign alu_en = is_reg | is_bit | is_imm | op_daa | op_tbl;
  assign no_flags = is_bit |
                    (is_reg && hi && (grp == 3'h5 || grp == 3'h7)) |
                    (is_imm && (ik == 3'h0 || ik == 3'h4 || ik == 3'h6));

  mid_alu u_alu (
    .op_in(alu_op),
    .a_in(acc_reg),
    .x_in(alu_x),
    .c_in(status_reg[STAT_C]),
    .dc_in(status_reg[STAT_DC]),
    .bit_in(bitn),
    .res_out(alu)
  );

  // ----------------------------------------
  // write targets
  // ----------------------------------------
  logic wr_r;
  logic wr_a;
  logic wr_pcl;
  logic wr_stat;
  logic wr_bank;
  logic wr_ext;
  logic [7:0] acc_val;
  logic upd_z;
  logic upd_c;
  logic upd_dc;

  assign wr_r = exe & ((is_reg & dst_r) | (is_bit & ~bkind[1]));
  assign wr_a = exe & ((is_reg & ~dst_r) | (is_imm & (ik != 3'h6)) |
                       op_daa | op_option_reg_to_acc | op_crd);
  assign wr_pcl = (wr_r & (d_eff == ADDR_PCL)) | (exe & op_tbl);
  assign wr_stat = wr_r & (d_eff == ADDR_STAT);
  assign wr_bank = wr_r & (d_eff == ADDR_BANK);
  assign wr_ext = wr_r & ~(d_eff inside {ADDR_PCL, ADDR_STAT, ADDR_BANK});
  assign acc_val = op_option_reg_to_acc ? option_reg : (op_crd ? ctrl_rdata_in : alu.res);
  assign upd_z = exe & alu_en & ~no_flags & alu.upd_z;
  assign upd_c = exe & alu_en & ~no_flags & alu.upd_c;
  assign upd_dc = exe & alu_en & ~no_flags & alu.upd_dc;

  always_comb begin
    status_next = status_reg;
    if (wr_stat) begin
      status_next = (status_reg & ~STAT_WR_MASK) | (alu.res & STAT_WR_MASK);
    end
    if (upd_z) begin
      status_next[STAT_Z] = alu.z;
    end
    if (upd_c) begin
      status_next[STAT_C] = alu.c;
    end
    if (upd_dc) begin
      status_next[STAT_DC] = alu.dc;
    end
    if (exe & (op_sleep_op | op_watchdog_clear_op)) begin
      status_next[STAT_T] = 1'b1;
      status_next[STAT_P] = op_watchdog_clear_op;
    end
  end

  // ----------------------------------------
  // program flow
  // ----------------------------------------
  logic do_pop;
  logic do_push;
  logic skip_cond;
  logic pc_change;
  logic [SP_W-1:0] sp_dec;
  logic [PC_W-1:0] jump_tgt;

  assign do_pop = exe & (op_ret | op_interrupt_exit_pop | op_pop_with_literal);
  assign do_push = exe & is_br & ~ir_reg[10];
  assign sp_dec = sp_reg - SP_W'(1);
  assign jump_tgt = {status_reg[STAT_PG_LSB+:3], ir_reg[9:0]};
  assign skip_cond = (is_reg & hi & (grp == 3'h5 || grp == 3'h7) & alu.z) |
                     (is_bit & (bkind == 2'b10) & ~rval[bitn]) |
                     (is_bit & (bkind == 2'b11) & rval[bitn]);
  assign pc_change = (exe & is_br) | do_pop | wr_pcl;
  assign pc_next = (exe & is_br) ? jump_tgt :
                   do_pop ? stack_reg[sp_dec] :
                   wr_pcl ? {pc_reg[PC_W-1:8], alu.res} :
                   (fetch & ~stall_reg) ? pc_reg + PC_W'(1) : pc_reg;

  // ----------------------------------------
  // sequencing registers
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      phase_reg <= 1'b0;
    end else if (run) begin
      phase_reg <= ~phase_reg;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ir_reg <= '0;
      ir_ok_reg <= 1'b0;
    end else if (fetch) begin
      ir_reg <= instr_in;
      ir_ok_reg <= ~skip_reg & ~stall_reg;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      skip_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else if (fetch) begin
      skip_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else if (exe) begin
      skip_reg <= skip_cond & ~pc_change;
      stall_reg <= pc_change;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      pc_reg <= RST_PC;
    end else begin
      pc_reg <= pc_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sp_reg <= '0;
    end else if (do_push) begin
      stack_reg[sp_reg] <= pc_reg;
      sp_reg <= sp_reg + SP_W'(1);
    end else if (do_pop) begin
      sp_reg <= sp_dec;
    end
  end

  // ----------------------------------------
  // data registers
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      acc_reg <= RST_ACC;
      status_reg <= RST_STATUS;
      bank_reg <= RST_BANK;
      option_reg <= RST_OPTION;
    end else begin
      status_reg <= status_next;
      if (wr_a) begin
        acc_reg <= acc_val;
      end
      if (wr_bank) begin
        bank_reg <= alu.res;
      end
      if (exe & op_acc_to_option_reg) begin
        option_reg <= acc_reg;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      int_en_reg <= 1'b0;
    end else if (exe & (op_eni | op_interrupt_exit_pop)) begin
      int_en_reg <= 1'b1;
    end else if (exe & op_interrupt_disable_op) begin
      int_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      sleep_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
      exec_reg <= 1'b0;
    end else begin
      if (exe & op_sleep_op) begin
        sleep_reg <= 1'b1;
      end else if (wake_in) begin
        sleep_reg <= 1'b0;
      end
      wdt_clr_reg <= exe & (op_sleep_op | op_watchdog_clear_op);
      exec_reg <= exe;
    end
  end

  // ----------------------------------------
  // register file access
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      bus_reg <= '0;
    end else if (fetch) begin
      bus_reg.addr <= f_addr;
      bus_reg.ctrl_sel <= ctrl_rd_op(instr_in);
      bus_reg.reg_we <= 1'b0;
      bus_reg.ctrl_we <= 1'b0;
    end else if (exe) begin
      bus_reg.wdata <= op_cwr ? acc_reg : alu.res;
      bus_reg.reg_we <= wr_ext;
      bus_reg.ctrl_we <= op_cwr;
    end else begin
      bus_reg.reg_we <= 1'b0;
      bus_reg.ctrl_we <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pc_out = pc_reg;
  assign bus_out = bus_reg;
  assign acc_out = acc_reg;
  assign status_out = status_reg;
  assign bank_out = bank_reg;
  assign option_out = option_reg;
  assign int_en_out = int_en_reg;
  assign sleep_out = sleep_reg;
  assign wdt_clear_out = wdt_clr_reg;
  assign exec_out = exec_reg;

endmodule : mid_core
`default_nettype wire

/* src/mid_pkg.sv */
// constants and types shared by the instruction decoder core
package mid_pkg;

  // ----------------------------------------
  // widths and timing
  // ----------------------------------------
  localparam int INSTR_W = 13;
  localparam int PC_W = 13;
  localparam int PHASES_PER_CYCLE = 2;
  localparam int BANK_LSB = 6;

  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int STAT_P = 3;
  localparam int STAT_T = 4;
  localparam int STAT_PG_LSB = 5;
  localparam logic [7:0] STAT_WR_MASK = 8'he7;

  // ----------------------------------------
  // internal register addresses
  // ----------------------------------------
  localparam logic [5:0] ADDR_IND = 6'h00;
  localparam logic [5:0] ADDR_PCL = 6'h02;
  localparam logic [5:0] ADDR_STAT = 6'h03;
  localparam logic [5:0] ADDR_BANK = 6'h04;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'h3f;
  localparam logic [PC_W-1:0] RST_PC = 13'h0000;

  // ----------------------------------------
  // fixed opcodes
  // ----------------------------------------
  localparam logic [INSTR_W-1:0] OP_DAA = 13'h0001;
  localparam logic [INSTR_W-1:0] OP_ACC_TO_OPTION_REG = 13'h0002;
  localparam logic [INSTR_W-1:0] OP_SLEEP_OP = 13'h0003;
  localparam logic [INSTR_W-1:0] OP_WATCHDOG_CLEAR_OP = 13'h0004;
  localparam logic [INSTR_W-1:0] OP_ENI = 13'h0010;
  localparam logic [INSTR_W-1:0] OP_INTERRUPT_DISABLE_OP = 13'h0011;
  localparam logic [INSTR_W-1:0] OP_RET = 13'h0012;
  localparam logic [INSTR_W-1:0] OP_INTERRUPT_EXIT_POP = 13'h0013;
  localparam logic [INSTR_W-1:0] OP_OPTION_REG_TO_ACC = 13'h0014;
  localparam logic [INSTR_W-1:0] OP_TBL = 13'h0020;
  localparam logic [3:0] CTRL_FIRST = 4'h5;

  typedef enum logic [4:0] {
    ALU_PASS = 5'b00000,
    ALU_PASSA = 5'b00001,
    ALU_ADD = 5'b00010,
    ALU_SUB = 5'b00011,
    ALU_OR = 5'b00100,
    ALU_AND = 5'b00101,
    ALU_XOR = 5'b00110,
    ALU_COM = 5'b00111,
    ALU_INC = 5'b01000,
    ALU_DEC = 5'b01001,
    ALU_RRC = 5'b01010,
    ALU_RLC = 5'b01011,
    ALU_SWAP = 5'b01100,
    ALU_ZERO = 5'b01101,
    ALU_DAA = 5'b01110,
    ALU_BCLR = 5'b01111,
    ALU_BSET = 5'b10000
  } mid_alu_op_t;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
  } mid_alu_res_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic reg_we;
    logic ctrl_we;
    logic ctrl_sel;
  } mid_bus_t;

endpackage : mid_pkg

/* test/mid_core_monitor.sv */
// assertion checker for the decoder core ports
`timescale 1ns/100ps
`default_nettype none
module mid_core_monitor #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [mid_pkg::INSTR_W-1:0] instr_in,
  input wire logic [mid_pkg::PC_W-1:0] pc_out,
  input wire mid_pkg::mid_bus_t bus_out,
  input wire logic [7:0] acc_out,
  input wire logic [7:0] status_out,
  input wire logic [7:0] bank_out,
  input wire logic int_en_out,
  input wire logic exec_out
);
  import mid_pkg::*;
  // ----------------------------------------
  // word that reaches execution, two edges after its fetch
  // ----------------------------------------
  logic [12:0] ir1_reg;
  logic [12:0] ir2_reg;
  always_ff @(posedge mclk_in) begin
    ir1_reg <= instr_in;
    ir2_reg <= ir1_reg;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  exec_gap_a: assert property (exec_out |=> !exec_out)
    else $error("exec pulses too close");
  bank_sel_a: assert property (bus_out.reg_we |-> bus_out.addr[7:6] == bank_out[7:6])
    else $error("write outside bank");
  we_pulse_a: assert property (bus_out.reg_we |=> !bus_out.reg_we)
    else $error("write pulse too long");
  int_en_a: assert property (exec_out && ir2_reg inside {13'h0010, 13'h0011}
    |-> int_en_out == !ir2_reg[0]) else $error("interrupt enable wrong");
  zero_only_a: assert property (exec_out && !ir2_reg[6]
    && ir2_reg[12:7] inside {6'h04, 6'h05, 6'h06, 6'h08, 6'h09}
    |-> status_out[2] == (acc_out == 8'h00) && status_out[1:0] == $past(status_out[1:0]))
    else $error("logic op flags wrong");
  carry_only_a: assert property (exec_out && ir2_reg[12:8] == 5'h06
    && ir2_reg[5:0] != 6'h03 |-> status_out[2:1] == $past(status_out[2:1]))
    else $error("rotate touched z or dc");
  swap_flags_a: assert property (exec_out && ir2_reg[12:7] == 6'h0e
    && ir2_reg[5:0] != 6'h03 |-> $stable(status_out[2:0])) else $error("swap changed flags");
  goto_pc_a: assert property (exec_out && ir2_reg[12:11] == 2'h2
    |-> pc_out == {status_out[7:5], ir2_reg[9:0]}) else $error("branch target wrong");
  goto_gap_a: assert property (exec_out && ir2_reg[12:11] == 2'h2 |=> !exec_out [*3])
    else $error("branch too short");
  lit_ret_a: assert property (exec_out && ir2_reg[12:8] == 5'h1c
    |-> acc_out == ir2_reg[7:0] && $stable(status_out[2:0])) else $error("literal return wrong");
endmodule : mid_core_monitor
bind mid_core mid_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) mid_mon (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .instr_in(instr_in), .pc_out(pc_out),
  .bus_out(bus_out), .acc_out(acc_out), .status_out(status_out), .bank_out(bank_out),
  .int_en_out(int_en_out), .exec_out(exec_out));
`default_nettype wire

/* test/mid_core_tb_top.sv */
// self-checking bench for the decoder core
`timescale 1ns/100ps
`default_nettype none
module mid_core_tb_top;
  import mid_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic wake = 1'b0;
  logic [12:0] instr;
  logic [12:0] pc;
  logic [7:0] rdata;
  logic [7:0] cdata;
  logic [7:0] acc;
  logic [7:0] status;
  logic [7:0] option;
  logic exec;
  logic int_en;
  logic watchdog_clear_op;
  mid_bus_t bus;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // program never bit-clears the fifo data port or flag bank
  logic [12:0] prog [18] = '{13'h18ff, 13'h0010, 13'h0011, 13'h1f01, 13'h0050, 13'h1805,
    13'h0150, 13'h0006, 13'h0080, 13'h0016, 13'h01d0, 13'h0410, 13'h0690, 13'h0710,
    13'h0e50, 13'h1800, 13'h1bff, 13'h1418};
  mid_core dut (.mclk_in(mclk), .resetn_in(resetn), .instr_in(instr), .reg_rdata_in(rdata),
    .ctrl_rdata_in(cdata), .wake_in(wake), .pc_out(pc), .bus_out(bus), .acc_out(acc),
    .status_out(status), .bank_out(), .option_out(option), .int_en_out(int_en), .sleep_out(),
    .wdt_clear_out(watchdog_clear_op), .exec_out(exec));
  mid_prog_mem pm (.mclk_in(mclk), .pc_in(pc), .bus_in(bus), .instr_out(instr),
    .reg_rdata_out(rdata), .ctrl_rdata_out(cdata));
  always #5 mclk = ~mclk;
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // wait for the next executed word, then compare acc and z dc c
  task automatic step(input logic [7:0] a, input logic [2:0] f);
    int n;
    n = 0;
    while (exec !== 1'b1 && n < 12) begin
      @(negedge mclk);
      n++;
    end
    check("exec", 8'h01, {7'h00, exec});
    check("acc", a, acc);
    check("flags", {5'h00, f}, {5'h00, status[2:0]});
    @(negedge mclk);
  endtask : step
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(negedge mclk);
    check("acc rst", 8'h00, acc);
    check("status rst", 8'h18, status);
    check("option rst", 8'h3f, option);
    check("pc rst", 8'h00, pc[7:0]);
    // program loaded after the memory model has filled itself
    foreach (prog[i]) pm.rom[i] = prog[i];
    pm.rom[24] = 13'h1020;
    pm.rom[25] = 13'h1fc4;
    pm.rom[26] = 13'h1f38;
    pm.rom[27] = 13'h1f68;
    pm.rom[28] = 13'h0001;
    pm.rom[29] = 13'h0002;
    pm.rom[30] = 13'h1800;
    pm.rom[31] = 13'h1428;
    pm.rom[32] = 13'h1c3c;
    pm.rom[40] = 13'h0014;
    pm.rom[41] = 13'h1802;
    pm.rom[42] = 13'h0020;
    pm.rom[45] = 13'h1033;
    pm.rom[46] = 13'h0004;
    pm.rom[47] = 13'h142f;
    pm.rom[51] = 13'h0013;
    resetn = 1'b1;
    step(8'hff, 3'h0);
    step(8'hff, 3'h0);
    step(8'hff, 3'h0);
    step(8'h00, 3'h7);
    step(8'h00, 3'h7);
    step(8'h05, 3'h7);
    step(8'h05, 3'h0);
    step(8'h05, 3'h0);
    step(8'h00, 3'h4);
    step(8'h05, 3'h4);
    step(8'h05, 3'h0);
    step(8'hfa, 3'h0);
    step(8'hf4, 3'h1);
    step(8'haf, 3'h1);
    step(8'haf, 3'h1);
    step(8'h50, 3'h1);
    step(8'h50, 3'h1);
    step(8'h50, 3'h1);
    step(8'h3c, 3'h1);
    step(8'h00, 3'h7);
    step(8'h38, 3'h0);
    step(8'ha0, 3'h2);
    step(8'h06, 3'h3);
    step(8'h06, 3'h3);
    check("option", 8'h06, option);
    step(8'h00, 3'h3);
    step(8'h00, 3'h3);
    step(8'h06, 3'h3);
    step(8'h02, 3'h3);
    step(8'h02, 3'h0);
    step(8'h02, 3'h0);
    step(8'h02, 3'h0);
    check("int en", 8'h01, {7'h00, int_en});
    while (exec !== 1'b1) @(negedge mclk);
    check("wdt clr", 8'h01, {7'h00, watchdog_clear_op});
    check("t p", 8'h03, {6'h00, status[4:3]});
    check("reg 10", 8'hfa, pm.regs[16]);
    check("ctl 6", 8'h05, pm.ctl[6]);
    complete_run();
  end
endmodule : mid_core_tb_top
`default_nettype wire

/* test/mid_prog_mem.sv */
// program memory and register files facing the decoder core
`timescale 1ns/100ps
`default_nettype none
module mid_prog_mem (
  input wire logic mclk_in,
  input wire logic [12:0] pc_in,
  input wire mid_pkg::mid_bus_t bus_in,
  output logic [12:0] instr_out,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] ctrl_rdata_out
);
  import mid_pkg::*;
  logic [12:0] rom [256];
  logic [7:0] regs [256];
  logic [7:0] ctl [16];
  initial begin
    foreach (rom[i]) rom[i] = 13'h1800;
    foreach (regs[i]) regs[i] = 8'h00;
    foreach (ctl[i]) ctl[i] = 8'h00;
  end
  // whole word at the program address
  assign instr_out = rom[pc_in[7:0]];
  assign reg_rdata_out = regs[bus_in.addr];
  assign ctrl_rdata_out = ctl[bus_in.addr[3:0]];
  always @(posedge mclk_in) begin
    if (bus_in.reg_we) regs[bus_in.addr] <= bus_in.wdata;
    if (bus_in.ctrl_we) ctl[bus_in.addr[3:0]] <= bus_in.wdata;
  end
endmodule : mid_prog_mem
`default_nettype wire
